// file: rtl/registered_bus_transceiver.sv
/*
 * eight-bit registered transceiver between a left and a right parallel bus,
 * with apb control, synchronised capture strobes and a two-entry capture log.
 * assumes both buses and both capture strobes are asynchronous to REF_CLK_I
 * and the board resolves each two-way pin from its output enable.
 */
`timescale 1ns/1ps

module registered_bus_transceiver
    import xcvr_pkg::*;
(
    input wire logic REF_CLK_I,
    input wire logic RST_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [ADDR_W-1:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic PREADY_O,
    output logic [31:0] PRDATA_O,
    output logic PSLVERR_O,
    input wire logic LEFT_CAPTURE_CLK_I,
    input wire logic RIGHT_CAPTURE_CLK_I,
    input wire logic [DATA_W-1:0] LEFT_I,
    output logic [DATA_W-1:0] LEFT_O,
    output logic LEFT_OE_O,
    input wire logic [DATA_W-1:0] RIGHT_I,
    output logic [DATA_W-1:0] RIGHT_O,
    output logic RIGHT_OE_O,
    output logic CAPQ_READY_O
);

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers: first stage feeds only the second

    logic [DATA_W-1:0] left_meta_ff;
    logic [DATA_W-1:0] left_sync_ff;
    logic [DATA_W-1:0] right_meta_ff;
    logic [DATA_W-1:0] right_sync_ff;
    logic [1:0] strobe_meta_ff;
    logic [1:0] strobe_sync_ff;
    logic [1:0] strobe_last_ff;

    always_ff @(posedge REF_CLK_I)
    begin
        left_meta_ff <= LEFT_I;
        left_sync_ff <= left_meta_ff;
        right_meta_ff <= RIGHT_I;
        right_sync_ff <= right_meta_ff;
        strobe_meta_ff <= {RIGHT_CAPTURE_CLK_I, LEFT_CAPTURE_CLK_I};
        strobe_sync_ff <= strobe_meta_ff;
        strobe_last_ff <= strobe_sync_ff;
    end

    // data and strobe share the same two-stage delay, so setup at the pins holds here
    logic left_edge;
    logic right_edge;
    assign left_edge = strobe_sync_ff[0] & ~strobe_last_ff[0];
    assign right_edge = strobe_sync_ff[1] & ~strobe_last_ff[1];

    ////////////////////////////////////////////////////////////////////////////
    // capture registers: no reset, undefined until first strobe

    logic [DATA_W-1:0] left_store_ff; // RL1
    logic [DATA_W-1:0] right_store_ff; // RL1

    // loaded on every rising strobe edge, never gated by control or drive state
    always_ff @(posedge REF_CLK_I)
    begin
        if (left_edge) // RL2 RL3 RL4 RL10 RL11
        begin
            left_store_ff <= left_sync_ff;
        end
        if (right_edge) // RL2 RL3 RL4 RL10 RL11
        begin
            right_store_ff <= right_sync_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control register

    ctrl_t ctrl_ff;
    logic bus_take;
    logic bus_write;
    logic bus_read;
    logic pready_ff;

    // one wait state: pready rises in the second access cycle
    assign bus_take = PSEL_I & PENABLE_I & pready_ff;
    assign bus_write = bus_take & PWRITE_I;
    assign bus_read = bus_take & ~PWRITE_I;

    always_ff @(posedge REF_CLK_I)
    begin
        if (RST_I)
        begin
            ctrl_ff <= ctrl_t'(CTRL_RST);
        end
        else if (bus_write && PADDR_I == CTRL_OFS)
        begin
            ctrl_ff <= ctrl_t'(PWDATA_I[3:0]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // port drive decode

    function automatic drive_t drive_of(input ctrl_t c);
        if (c.enable_n)
        begin
            drive_of = DRV_NONE; // RL4
        end
        else if (c.dir)
        begin
            drive_of = DRV_RIGHT;
        end
        else
        begin
            drive_of = DRV_LEFT;
        end
    endfunction

    drive_t drive;
    assign drive = drive_of(ctrl_ff);

    // outputs lag the pins by the sync stages plus one; fine for slow buses only
    always_ff @(posedge REF_CLK_I)
    begin
        if (RST_I)
        begin
            LEFT_OE_O <= 1'b0;
            RIGHT_OE_O <= 1'b0;
            LEFT_O <= PIN_RST;
            RIGHT_O <= PIN_RST;
        end
        else
        begin
            LEFT_OE_O <= (drive == DRV_LEFT); // RL9
            RIGHT_OE_O <= (drive == DRV_RIGHT); // RL9
            LEFT_O <= ctrl_ff.r2l_sel ? right_store_ff : right_sync_ff; // RL5 RL6
            RIGHT_O <= ctrl_ff.l2r_sel ? left_store_ff : left_sync_ff; // RL7 RL8
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // two-entry capture log, drained by reads of the queue register

    cap_word_t capq_mem [FIFO_DEPTH];
    logic wr_ptr_ff;
    logic rd_ptr_ff;
    logic [1:0] count_ff;
    logic full_ff;
    logic ovf_ff;
    logic push_valid;
    logic push;
    logic pop;
    cap_word_t push_word;

    assign push_valid = left_edge | right_edge;
    assign pop = bus_read && PADDR_I == CAPQ_OFS && count_ff != 2'd0;
    // a full log still accepts a word in the cycle that one is popped
    assign push = push_valid & (~full_ff | pop);
    assign push_word = '{right_hit: right_edge, left_hit: left_edge,
                         right: right_sync_ff, left: left_sync_ff};

    always_ff @(posedge REF_CLK_I)
    begin
        if (push)
        begin
            capq_mem[wr_ptr_ff] <= push_word;
        end
    end

    always_ff @(posedge REF_CLK_I)
    begin
        if (RST_I)
        begin
            wr_ptr_ff <= 1'b0;
            rd_ptr_ff <= 1'b0;
            count_ff <= 2'd0;
            full_ff <= 1'b0;
            CAPQ_READY_O <= 1'b1;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_ff <= ~wr_ptr_ff;
            end
            if (pop)
            begin
                rd_ptr_ff <= ~rd_ptr_ff;
            end
            case ({push, pop})
                2'b10:
                begin
                    count_ff <= count_ff + 2'd1;
                    full_ff <= (count_ff == 2'd1);
                    CAPQ_READY_O <= (count_ff != 2'd1);
                end
                2'b01:
                begin
                    count_ff <= count_ff - 2'd1;
                    full_ff <= 1'b0;
                    CAPQ_READY_O <= 1'b1;
                end
                default:
                begin
                    count_ff <= count_ff;
                end
            endcase
        end
    end

    // strobes cannot be held off, so a word refused by a full log is flagged;
    // a new loss in the clearing cycle keeps the flag set
    always_ff @(posedge REF_CLK_I)
    begin
        if (RST_I)
        begin
            ovf_ff <= 1'b0;
        end
        else if (push_valid && !push)
        begin
            ovf_ff <= 1'b1;
        end
        else if (bus_write && PADDR_I == STATUS_OFS && PWDATA_I[STAT_OVF_BIT])
        begin
            ovf_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // apb read mux and answer

    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        mapped = (a == CTRL_OFS) || (a == LEFT_REG_OFS) || (a == RIGHT_REG_OFS)
              || (a == STATUS_OFS) || (a == CAPQ_OFS);
    endfunction

    logic [31:0] nxt_rdata;

    always_comb
    begin
        nxt_rdata = RDATA_RST;
        case (PADDR_I)
            CTRL_OFS:
            begin
                nxt_rdata[3:0] = ctrl_ff;
            end
            LEFT_REG_OFS:
            begin
                nxt_rdata[DATA_W-1:0] = left_store_ff;
            end
            RIGHT_REG_OFS:
            begin
                nxt_rdata[DATA_W-1:0] = right_store_ff;
            end
            STATUS_OFS:
            begin
                nxt_rdata[STAT_LEFT_OE_BIT] = LEFT_OE_O;
                nxt_rdata[STAT_RIGHT_OE_BIT] = RIGHT_OE_O;
                nxt_rdata[STAT_COUNT_LSB +: 2] = count_ff;
                nxt_rdata[STAT_OVF_BIT] = ovf_ff;
            end
            CAPQ_OFS:
            begin
                nxt_rdata[CAPQ_LEFT_LSB +: DATA_W] = capq_mem[rd_ptr_ff].left;
                nxt_rdata[CAPQ_RIGHT_LSB +: DATA_W] = capq_mem[rd_ptr_ff].right;
                nxt_rdata[CAPQ_LEFT_HIT_BIT] = capq_mem[rd_ptr_ff].left_hit;
                nxt_rdata[CAPQ_RIGHT_HIT_BIT] = capq_mem[rd_ptr_ff].right_hit;
                nxt_rdata[CAPQ_VALID_BIT] = 1'b1;
                if (count_ff == 2'd0)
                begin
                    nxt_rdata = RDATA_RST;
                end
            end
            default:
            begin
                nxt_rdata = RDATA_RST;
            end
        endcase
    end

    always_ff @(posedge REF_CLK_I)
    begin
        if (RST_I)
        begin
            pready_ff <= 1'b0;
            PRDATA_O <= RDATA_RST;
            PSLVERR_O <= 1'b0;
        end
        else
        begin
            pready_ff <= PSEL_I & PENABLE_I & ~pready_ff;
            PRDATA_O <= nxt_rdata;
            PSLVERR_O <= PSEL_I & PENABLE_I & ~pready_ff & ~mapped(PADDR_I);
        end
    end

    assign PREADY_O = pready_ff;

endmodule // registered_bus_transceiver

// file: pkg/xcvr_pkg.sv
/*
 * constants, field layouts and carrier types for the registered bus transceiver.
 * assumes one 50 MHz clock, an apb master on the register side, and two 8-bit
 * parallel buses whose capture strobes arrive as asynchronous pins.
 */
// Summary of operation
// [RL1] two independent eight-bit capture registers
// [RL2] rising strobe edge loads that port's pins
// [RL3] capture ignores enable, direction and selects
// [RL4] enable high: both ports inputs, capture works
// [RL5] dir low, select low: live right to left
// [RL6] dir low, select high: stored right to left
// [RL7] dir high, select low: live left to right
// [RL8] dir high, select high: stored left to right
// [RL9] never drive both ports together
// [RL10] undriven port still captures its own pins
// [RL11] capture registers have no reset
package xcvr_pkg;

    localparam int DATA_W = 8;
    localparam int ADDR_W = 8;
    localparam int FIFO_DEPTH = 2;
    localparam real CLK_PERIOD_NS = 20.0;

    ////////////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] LEFT_REG_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] RIGHT_REG_OFS = 8'h08;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h0c;
    localparam logic [ADDR_W-1:0] CAPQ_OFS = 8'h10;

    ////////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int CTRL_EN_N_BIT = 0;
    localparam int CTRL_DIR_BIT = 1;
    localparam int CTRL_L2R_SEL_BIT = 2;
    localparam int CTRL_R2L_SEL_BIT = 3;
    localparam int STAT_LEFT_OE_BIT = 0;
    localparam int STAT_RIGHT_OE_BIT = 1;
    localparam int STAT_COUNT_LSB = 4;
    localparam int STAT_OVF_BIT = 8;
    localparam int CAPQ_LEFT_LSB = 0;
    localparam int CAPQ_RIGHT_LSB = 8;
    localparam int CAPQ_LEFT_HIT_BIT = 16;
    localparam int CAPQ_RIGHT_HIT_BIT = 17;
    localparam int CAPQ_VALID_BIT = 31;

    ////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [3:0] CTRL_RST = 4'h1;
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;
    localparam logic [DATA_W-1:0] PIN_RST = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // carrier types
    typedef struct packed {
        logic r2l_sel;
        logic l2r_sel;
        logic dir;
        logic enable_n;
    } ctrl_t;

    typedef struct packed {
        logic right_hit;
        logic left_hit;
        logic [DATA_W-1:0] right;
        logic [DATA_W-1:0] left;
    } cap_word_t;

    typedef enum logic [1:0] {
        DRV_NONE = 2'b00,
        DRV_LEFT = 2'b01,
        DRV_RIGHT = 2'b10
    } drive_t;

endpackage

// file: bench/xcvr_asserts.sv
/*
 * port checker for the registered bus transceiver.
 * assumes it is bound to the top module and sees its ports only.
 */
`timescale 1ns/1ps

module xcvr_asserts
    import xcvr_pkg::*;
(
    input logic REF_CLK_I,
    input logic RST_I,
    input logic PSEL_I,
    input logic PENABLE_I,
    input logic PWRITE_I,
    input logic [ADDR_W-1:0] PADDR_I,
    input logic [31:0] PWDATA_I,
    input logic PREADY_O,
    input logic PSLVERR_O,
    input logic [DATA_W-1:0] LEFT_I,
    input logic [DATA_W-1:0] LEFT_O,
    input logic LEFT_OE_O,
    input logic [DATA_W-1:0] RIGHT_I,
    input logic [DATA_W-1:0] RIGHT_O,
    input logic RIGHT_OE_O
);
    // shadow of the control register, kept from accepted apb writes
    ctrl_t ctrl_ff;
    logic oe_l, oe_r, live_l, live_r;
    always_ff @(posedge REF_CLK_I)
        if (RST_I)
            ctrl_ff <= ctrl_t'(CTRL_RST);
        else if (PSEL_I && PENABLE_I && PREADY_O && PWRITE_I && PADDR_I == CTRL_OFS)
            ctrl_ff <= ctrl_t'(PWDATA_I[3:0]);
    assign oe_l = !ctrl_ff.enable_n && !ctrl_ff.dir;
    assign oe_r = !ctrl_ff.enable_n && ctrl_ff.dir;
    assign live_l = LEFT_OE_O && !ctrl_ff.r2l_sel;
    assign live_r = RIGHT_OE_O && !ctrl_ff.l2r_sel;
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (RST_I);
    ////////////////////////////////////////////////////////////
    property p_excl; !(LEFT_OE_O && RIGHT_OE_O); endproperty
    a_excl: assert property (p_excl) else $error("both ports driven");
    property p_wait; (PSEL_I && !PENABLE_I) ##1 (PSEL_I && PENABLE_I) |=> PREADY_O; endproperty
    a_wait: assert property (p_wait) else $error("ready late");
    property p_pulse; PREADY_O |=> !PREADY_O; endproperty
    a_pulse: assert property (p_pulse) else $error("ready held");
    property p_err; PSLVERR_O |-> PREADY_O && PSEL_I && PENABLE_I; endproperty
    a_err: assert property (p_err) else $error("stray error");
    // enables follow control one edge later; a reset edge forces them low first
    property p_oe_l; LEFT_OE_O == ($past(RST_I) ? 1'b0 : $past(oe_l)); endproperty
    a_oe_l: assert property (p_oe_l) else $error("left enable wrong");
    property p_oe_r; RIGHT_OE_O == ($past(RST_I) ? 1'b0 : $past(oe_r)); endproperty
    a_oe_r: assert property (p_oe_r) else $error("right enable wrong");
    // four quiet cycles cover the two sync stages and the output flop
    property p_live_l; (live_l && $stable(RIGHT_I))[*4] |-> LEFT_O == RIGHT_I; endproperty
    a_live_l: assert property (p_live_l) else $error("left live data wrong");
    property p_live_r; (live_r && $stable(LEFT_I))[*4] |-> RIGHT_O == LEFT_I; endproperty
    a_live_r: assert property (p_live_r) else $error("right live data wrong");
endmodule // xcvr_asserts

bind registered_bus_transceiver xcvr_asserts u_xcvr_asserts (.REF_CLK_I, .RST_I, .PSEL_I, .PENABLE_I,
    .PWRITE_I, .PADDR_I, .PWDATA_I, .PREADY_O, .PSLVERR_O, .LEFT_I, .LEFT_O, .LEFT_OE_O, .RIGHT_I,
    .RIGHT_O, .RIGHT_OE_O);

// file: bench/bus_partner.sv
/*
 * far-side buses: resolves each two-way pin from the enables.
 * assumes the bench drives the far-side values at all times.
 */
`timescale 1ns/1ps

module bus_partner (
    input logic [7:0] ext_l_i,
    input logic [7:0] ext_r_i,
    input logic [7:0] dev_l_i,
    input logic dev_l_oe_i,
    input logic [7:0] dev_r_i,
    input logic dev_r_oe_i,
    output logic [7:0] pin_l_o,
    output logic [7:0] pin_r_o
);
    // far side lets go of a port while the device drives it
    assign pin_l_o = dev_l_oe_i ? dev_l_i : ext_l_i;
    assign pin_r_o = dev_r_oe_i ? dev_r_i : ext_r_i;
endmodule // bus_partner

// file: bench/testbench.sv
/*
 * self-checking bench: apb master, strobes, model of stores and log.
 * assumes the design answers every apb access; the bench polls ready, so the wait state count may vary.
 */
`timescale 1ns/1ps

module testbench;
    import xcvr_pkg::*;
    logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, lck = 0, rck = 0, er;
    logic [7:0] paddr = 8'h00, ext_l = 8'h00, ext_r = 8'h00, lo, ro, li, ri, sv, ev;
    logic [31:0] pwdata = 32'h0, prd, rd;
    logic loe, roe, prdy, perr, cqr;
    logic [15:0] lf = 16'hc9c5;
    int failures = 0, checks_done = 0;
    logic [31:0] q[$];
    always #10 clk = ~clk;
    registered_bus_transceiver u_registered_bus_transceiver (.REF_CLK_I(clk), .RST_I(rst), .PSEL_I(psel),
        .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PREADY_O(prdy),
        .PRDATA_O(prd), .PSLVERR_O(perr), .LEFT_CAPTURE_CLK_I(lck), .RIGHT_CAPTURE_CLK_I(rck),
        .LEFT_I(li), .LEFT_O(lo), .LEFT_OE_O(loe), .RIGHT_I(ri), .RIGHT_O(ro), .RIGHT_OE_O(roe),
        .CAPQ_READY_O(cqr));
    bus_partner u_bus_partner (.ext_l_i(ext_l), .ext_r_i(ext_r), .dev_l_i(lo), .dev_l_oe_i(loe),
        .dev_r_i(ro), .dev_r_oe_i(roe), .pin_l_o(li), .pin_r_o(ri));
    ////////////////////////////////////////////////////////////
    function automatic logic [7:0] rnd();
        lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
        return lf[7:0];
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // no fixed wait: poll ready; only the watchdog ends a dead wait
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1;
        do
        begin
            @(posedge clk);
        end while (prdy !== 1'b1);
        rd = prd;
        er = perr;
        psel <= 0;
        pen <= 0;
        @(posedge clk);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        apb(0, a, 32'h0);
        chk(rd, e);
    endtask
    // pins settle three clocks each side of the edge for the synchroniser
    task automatic strobe(input logic l, input logic r);
        repeat (3) @(posedge clk);
        lck <= l;
        rck <= r;
        repeat (3) @(posedge clk);
        lck <= 0;
        rck <= 0;
        repeat (4) @(posedge clk);
    endtask
    task tally_and_finish;
        if (failures == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    initial
    begin
        repeat (12) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        rdchk(CTRL_OFS, 32'h1);
        apb(1, CTRL_OFS, 32'hf);
        ext_l <= rnd();
        ext_r <= rnd();
        strobe(1, 1);
        chk({30'h0, loe, roe}, 32'h0);
        rdchk(LEFT_REG_OFS, {24'h0, ext_l});
        rdchk(RIGHT_REG_OFS, {24'h0, ext_r});
        for (int m = 0; m < 4; m++)
        begin
            apb(1, CTRL_OFS, {28'h0, m[1], m[1], m[0], 1'b0});
            ext_l <= rnd();
            ext_r <= rnd();
            strobe(m[0], !m[0]);
            sv = m[0] ? ext_l : ext_r;
            if (m[0])
                ext_l <= rnd();
            else
                ext_r <= rnd();
            repeat (8) @(posedge clk);
            ev = m[1] ? sv : (m[0] ? ext_l : ext_r);
            if (m[0])
                chk({22'h0, roe, loe, ro}, {22'h0, 2'b10, ev});
            else
                chk({22'h0, loe, roe, lo}, {22'h0, 2'b10, ev});
            rdchk(m[0] ? LEFT_REG_OFS : RIGHT_REG_OFS, {24'h0, sv});
        end
        apb(1, CTRL_OFS, 32'h1);
        repeat (4) apb(0, CAPQ_OFS, 32'h0);
        for (int k = 0; k < 3; k++)
        begin
            ext_l <= rnd();
            strobe(1, 0);
            if (k < 2)
                q.push_back({1'b1, 13'h0, 2'b01, ext_r, ext_l});
        end
        chk({31'h0, cqr}, 32'h0);
        rdchk(STATUS_OFS, 32'h120);
        repeat (2) rdchk(CAPQ_OFS, q.pop_front());
        rdchk(CAPQ_OFS, 32'h0);
        chk({31'h0, cqr}, 32'h1);
        apb(1, STATUS_OFS, 32'h100);
        rdchk(STATUS_OFS, 32'h0);
        rdchk(8'h14, 32'h0);
        chk({31'h0, er}, 32'h1);
        // mid-run reset from a driving mode: enables must drop at once
        apb(1, CTRL_OFS, 32'h0);
        repeat (4) @(posedge clk);
        chk({30'h0, loe, roe}, 32'h2);
        rst <= 1;
        @(posedge clk);
        rst <= 0;
        @(posedge clk);
        chk({30'h0, loe, roe}, 32'h0);
        rdchk(CTRL_OFS, 32'h1);
        rdchk(STATUS_OFS, 32'h0);
        tally_and_finish();
    end
    initial
    begin
        repeat (5000) @(posedge clk);
        failures++;
        tally_and_finish();
    end
endmodule // testbench
